/* File: dv/tef_timer_flags_test.sv */
// Purpose: self-checking bench for timer event flags and software triggers
// Assumes: one wait state per bus access, event pulses seen at next edge
// Notes: mismatches, bus timeouts and the verdict are the only printed lines
`timescale 1ns/1ps
module tef_timer_flags_test import tef_pkg::*;;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       address = 8'h00;
  logic             read = 1'b0;
  logic             write = 1'b0;
  logic [31:0]      writedata = 32'h0;
  logic [3:0]       byteenable = 4'h0;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic             capture_event = 1'b0;
  logic             compare_event = 1'b0;
  logic             hw_update_event = 1'b0;
  logic [CNT_W-1:0] counter_value = 16'h0000;
  logic             update_event_flag, channel_event_flag, capture_overrun_flag;
  logic             update_event, counter_clear, prescaler_clear, channel_event;
  logic [CNT_W-1:0] capture_value;
  logic             channel_input, update_inhibit;
  int               err_total = 0;
  int               checked = 0;

  tef_timer_flags dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .capture_event(capture_event),
    .compare_event(compare_event), .hw_update_event(hw_update_event),
    .counter_value(counter_value), .update_event_flag(update_event_flag),
    .channel_event_flag(channel_event_flag), .capture_overrun_flag(capture_overrun_flag),
    .update_event(update_event), .counter_clear(counter_clear),
    .prescaler_clear(prescaler_clear), .channel_event(channel_event),
    .capture_value(capture_value), .channel_input(channel_input),
    .update_inhibit(update_inhibit));

  always #10 mclk = ~mclk;

  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one access; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      err_total++;
      $display("BAD %0t bus access never completed", $time);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] r;
    bus(1'b1, a, d, be, r);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(r, exp);
  endtask

  // one-cycle event pulse, then settle after the answering edge
  task automatic ev(input logic c, input logic m, input logic u, input logic [15:0] v);
    @(posedge mclk);
    capture_event <= c;
    compare_event <= m;
    hw_update_event <= u;
    counter_value <= v;
    @(posedge mclk);
    capture_event <= 1'b0;
    compare_event <= 1'b0;
    hw_update_event <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    rdchk(OFS_FLAGS, 32'h0);
    rdchk(OFS_CHMODE, 32'h0);
    rdchk(OFS_SWEVG, 32'h0);
    rdchk(8'h40, 32'h0);
  endtask

  task automatic t_capture();
    wr(OFS_CHMODE, 32'h1);
    chk(channel_input, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 16'h1234);
    chk(channel_event_flag, 1'b1);
    chk(capture_value, 16'h1234);
    chk(capture_overrun_flag, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 16'h2222);
    chk(capture_overrun_flag, 1'b1);
    repeat (5) @(posedge mclk);
    #1 chk(channel_event_flag, 1'b1);
    wr(OFS_FLAGS, 32'hFFFFFFFF);
    rdchk(OFS_FLAGS, 32'h202);
    wr(OFS_FLAGS, 32'hFFFFFFFD);
    rdchk(OFS_FLAGS, 32'h200);
    wr(OFS_FLAGS, 32'h0);
    rdchk(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_compare();
    ev(1'b0, 1'b1, 1'b0, 16'h0001);
    chk(channel_event_flag, 1'b0);
    wr(OFS_CHMODE, 32'h0);
    chk(channel_input, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 16'h0002);
    chk(channel_event_flag, 1'b0);
    ev(1'b0, 1'b1, 1'b0, 16'h0003);
    chk(channel_event_flag, 1'b1);
    wr(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_swgen();
    wr(OFS_CHMODE, 32'h1);
    @(posedge mclk);
    counter_value <= 16'hABCD;
    wr(OFS_SWEVG, 32'h2);
    chk(channel_event, 1'b1);
    chk(channel_event_flag, 1'b1);
    chk(capture_value, 16'hABCD);
    chk(capture_overrun_flag, 1'b0);
    @(posedge mclk);
    #1 chk(channel_event, 1'b0);
    rdchk(OFS_SWEVG, 32'h0);
    wr(OFS_SWEVG, 32'h2);
    chk(capture_overrun_flag, 1'b1);
    wr(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_update();
    wr(OFS_SWEVG, 32'h1);
    chk(counter_clear, 1'b1);
    chk(prescaler_clear, 1'b1);
    chk(update_event, 1'b1);
    chk(update_event_flag, 1'b1);
    @(posedge mclk);
    #1 chk(counter_clear, 1'b0);
    wr(OFS_FLAGS, 32'h0);
    chk(update_event_flag, 1'b0);
    ev(1'b0, 1'b0, 1'b1, 16'h0);
    chk(update_event_flag, 1'b1);
    wr(OFS_FLAGS, 32'h0);
  endtask

  task automatic t_inhibit();
    wr(OFS_CTRL, 32'h2);
    chk(update_inhibit, 1'b1);
    wr(OFS_SWEVG, 32'h1);
    chk(counter_clear, 1'b1);
    chk(prescaler_clear, 1'b1);
    chk(update_event, 1'b0);
    chk(update_event_flag, 1'b0);
    wr(OFS_CTRL, 32'h0);
  endtask

  task automatic t_partial();
    wr(OFS_CHMODE, 32'h0);
    wr(OFS_CHMODE, 32'h1, 4'h1);
    rdchk(OFS_CHMODE, 32'h0);
    chk(channel_input, 1'b0);
  endtask

  // reserved direction: no hardware events, software event sets flag without capture or overrun
  task automatic t_reserved();
    wr(OFS_CHMODE, 32'h2);
    chk(channel_input, 1'b0);
    ev(1'b1, 1'b1, 1'b0, 16'h5555);
    chk(channel_event_flag, 1'b0);
    chk(channel_event, 1'b0);
    wr(OFS_SWEVG, 32'h2);
    chk(channel_event_flag, 1'b1);
    chk(capture_value, 16'hABCD);
    chk(capture_overrun_flag, 1'b0);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_CHMODE, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_capture();
    t_compare();
    t_swgen();
    t_update();
    t_inhibit();
    t_partial();
    t_reserved();
    end_sim();
  end
endmodule // tef_timer_flags_test

/* File: logic/tef_avmm_port.sv */
// Purpose: Avalon-MM handshake, one wait state per access
// Assumes: master holds request until waitrequest sampled low
// Notes: readdata loaded at the same edge that waitrequest drops
`timescale 1ns/1ps
module tef_avmm_port import tef_pkg::*; (
  input  wire logic        mclk,        // kernel clock
  input  wire logic        reset,       // async, active high
  input  wire logic        read,        // bus read request
  input  wire logic        write,       // bus write request
  input  wire logic [31:0] rdata_in,    // decoded read value
  output logic      [31:0] readdata,    // registered read data
  output logic             waitrequest, // low in the accept cycle
  output logic             wr_stb       // write commits at next edge
);
  typedef struct packed {
    tef_bus_e    st;
    logic        wait_q;
    logic [31:0] rdata;
  } tef_port_s;

  tef_port_s s_q;
  tef_port_s s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      TEF_BUS_IDLE: begin
        if (read || write) begin
          s_d.st     = TEF_BUS_DONE;
          s_d.wait_q = 1'b0;
          if (read) begin
            s_d.rdata = rdata_in;
          end
        end
      end
      TEF_BUS_DONE: begin
        s_d.st     = TEF_BUS_IDLE;
        s_d.wait_q = 1'b1;
      end
      default: begin
        s_d.st     = TEF_BUS_IDLE;
        s_d.wait_q = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: TEF_BUS_IDLE, wait_q: 1'b1, rdata: RST_RDATA};
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata    = s_q.rdata;
  assign waitrequest = s_q.wait_q;
  assign wr_stb      = (s_q.st == TEF_BUS_DONE) && write;
endmodule // tef_avmm_port

/* File: logic/tef_pkg.sv */
// Purpose: constants for timer event flags and software event triggers
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes: reserved bits read as zero
// Contract
// R1: input mode capture sets channel event flag
// R2: output mode compare sets channel event flag
// R3: channel flag set by hardware, software clears
// R4: every update event sets update flag
// R5: flag bits clear on zero, ones unchanged
// R6: channel generate bit fires event, self-clears
// R7: software channel event sets flag, requests
// R8: software input event captures counter value
// R9: capture while flag set raises overrun
// R10: update generate bit writable, self-clears
// R11: update generate resets main counter
// R12: prescaler cleared together with counter
// R13: channel mode register accessed by words
// R14: inhibited update request reinitialises, no event
// R15: direction 00 output, 01 input
package tef_pkg;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_FLAGS    = 8'h10;
  localparam logic [7:0]  OFS_SWEVG    = 8'h14;
  localparam logic [7:0]  OFS_CHMODE   = 8'h18;
  localparam logic [7:0]  OFS_CAPVAL   = 8'h34;
  localparam int          BIT_INHIBIT  = 1;
  localparam int          BIT_UPD_FLAG = 0;
  localparam int          BIT_CH_FLAG  = 1;
  localparam int          BIT_OVR_FLAG = 9;
  localparam int          BIT_UPD_GEN  = 0;
  localparam int          BIT_CH_GEN   = 1;
  localparam int          CNT_W        = 16;
  localparam int          CHMODE_W     = 8;
  localparam logic [1:0]  DIR_OUTPUT   = 2'h0;
  localparam logic [1:0]  DIR_INPUT    = 2'h1;
  localparam logic [3:0]  BE_WORD      = 4'hF;
  localparam logic [CHMODE_W-1:0] RST_CHMODE = 8'h00;
  localparam logic [CNT_W-1:0]    RST_CAPVAL = 16'h0000;
  localparam logic [31:0] RST_RDATA    = 32'h00000000;
  typedef enum logic [0:0] {TEF_BUS_IDLE, TEF_BUS_DONE} tef_bus_e;
endpackage

/* File: logic/tef_timer_flags.sv */
// Purpose: timer status flags and software event generation
// Assumes: event inputs come from timer logic on mclk
// Notes: pulses last one cycle; flags are sticky
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module tef_timer_flags import tef_pkg::*; (
  input  wire logic             mclk,                 // kernel clock
  input  wire logic             reset,                // async, active high
  input  wire logic [7:0]       address,              // byte address
  input  wire logic             read,                 // bus read
  input  wire logic             write,                // bus write
  input  wire logic [31:0]      writedata,            // bus write data
  input  wire logic [3:0]       byteenable,           // bus byte lanes
  output logic      [31:0]      readdata,             // bus read data
  output logic                  waitrequest,          // bus stall
  input  wire logic             capture_event,        // channel capture
  input  wire logic             compare_event,        // channel compare match
  input  wire logic             hw_update_event,      // counter update
  input  wire logic [CNT_W-1:0] counter_value,        // main counter
  output logic                  update_event_flag,    // sticky update flag
  output logic                  channel_event_flag,   // sticky channel flag
  output logic                  capture_overrun_flag, // sticky overrun flag
  output logic                  update_event,         // update pulse
  output logic                  counter_clear,        // counter reset pulse
  output logic                  prescaler_clear,      // prescaler reset pulse
  output logic                  channel_event,        // irq/dma request pulse
  output logic      [CNT_W-1:0] capture_value,        // captured count
  output logic                  channel_input,        // channel in input mode
  output logic                  update_inhibit        // software update event off
);
  typedef struct packed {
    logic                upd_flag;
    logic                ch_flag;
    logic                ovr_flag;
    logic                inhibit;
    logic [CHMODE_W-1:0] chmode;
    logic [CNT_W-1:0]    capval;
    logic                upd_evt;
    logic                cnt_clr;
    logic                psc_clr;
    logic                ch_evt;
    logic                ch_in;
  } tef_core_s;

  tef_core_s   s_q;
  tef_core_s   s_d;
  logic [31:0] rdata_mux;
  logic        wr_stb;
  logic        wr_flags;
  logic        wr_swevg;
  logic        sw_upd;
  logic        sw_ch;
  logic        is_input;
  logic        is_output;
  logic        cap_hit;
  logic        ch_set;
  logic        upd_set;

  tef_avmm_port u_port (
    .mclk        (mclk),
    .reset       (reset),
    .read        (read),
    .write       (write),
    .rdata_in    (rdata_mux),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .wr_stb      (wr_stb)
  );

  // read decode, unmapped reads zero
  always_comb begin
    rdata_mux = RST_RDATA;
    case (address)
      OFS_CTRL: begin
        rdata_mux[BIT_INHIBIT] = s_q.inhibit;
      end
      OFS_FLAGS: begin
        rdata_mux[BIT_UPD_FLAG] = s_q.upd_flag;
        rdata_mux[BIT_CH_FLAG]  = s_q.ch_flag;
        rdata_mux[BIT_OVR_FLAG] = s_q.ovr_flag;
      end
      OFS_CHMODE: begin
        rdata_mux[CHMODE_W-1:0] = s_q.chmode;
      end
      OFS_CAPVAL: begin
        rdata_mux[CNT_W-1:0] = s_q.capval;
      end
      default: begin
        rdata_mux = RST_RDATA;
      end
    endcase
  end

  // R15: direction decode
  assign is_output = s_q.chmode[1:0] == DIR_OUTPUT;
  assign is_input  = s_q.chmode[1:0] == DIR_INPUT;

  assign wr_flags = wr_stb && (address == OFS_FLAGS);
  assign wr_swevg = wr_stb && (address == OFS_SWEVG) && byteenable[0];
  // R6: channel generate strobe
  assign sw_ch    = wr_swevg && writedata[BIT_CH_GEN];
  // R10: update generate strobe
  assign sw_upd   = wr_swevg && writedata[BIT_UPD_GEN];

  // R1: capture in input mode
  assign cap_hit = is_input && (capture_event || sw_ch);
  // R2: compare in output mode
  assign ch_set  = cap_hit || (is_output && compare_event) || sw_ch;
  // R14: inhibit blocks software update event
  assign upd_set = hw_update_event || (sw_upd && !s_q.inhibit);

  always_comb begin
    s_d         = s_q;
    s_d.upd_evt = upd_set;
    // R11: counter reset on update request
    s_d.cnt_clr = sw_upd;
    // R12: prescaler cleared alongside counter
    s_d.psc_clr = sw_upd;
    // R7: request pulse on channel event
    s_d.ch_evt  = ch_set;
    // R5: zero clears, one keeps
    if (wr_flags && byteenable[0]) begin
      s_d.upd_flag = s_q.upd_flag && writedata[BIT_UPD_FLAG];
      s_d.ch_flag  = s_q.ch_flag && writedata[BIT_CH_FLAG];
    end
    if (wr_flags && byteenable[1]) begin
      s_d.ovr_flag = s_q.ovr_flag && writedata[BIT_OVR_FLAG];
    end
    // R4: update sets flag, set wins
    if (upd_set) begin
      s_d.upd_flag = 1'b1;
    end
    // R3: hardware or software channel event sets, set wins
    if (ch_set) begin
      s_d.ch_flag = 1'b1;
    end
    // R9: overrun on capture with flag set
    if (cap_hit && s_q.ch_flag) begin
      s_d.ovr_flag = 1'b1;
    end
    // R8: capture counter into value register
    if (cap_hit) begin
      s_d.capval = counter_value;
    end
    if (wr_stb && (address == OFS_CTRL) && byteenable[0]) begin
      s_d.inhibit = writedata[BIT_INHIBIT];
    end
    // R13: partial writes ignored
    if (wr_stb && (address == OFS_CHMODE) && (byteenable == BE_WORD)) begin
      s_d.chmode = writedata[CHMODE_W-1:0];
    end
    // registered copy of the input-mode decode for the port
    s_d.ch_in = s_d.chmode[1:0] == DIR_INPUT;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '{upd_flag: 1'b0, ch_flag: 1'b0, ovr_flag: 1'b0,
               inhibit: 1'b0, chmode: RST_CHMODE, capval: RST_CAPVAL,
               upd_evt: 1'b0, cnt_clr: 1'b0, psc_clr: 1'b0,
               ch_evt: 1'b0, ch_in: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign update_event_flag    = s_q.upd_flag;
  assign channel_event_flag   = s_q.ch_flag;
  assign capture_overrun_flag = s_q.ovr_flag;
  assign update_event         = s_q.upd_evt;
  assign counter_clear        = s_q.cnt_clr;
  assign prescaler_clear      = s_q.psc_clr;
  assign channel_event        = s_q.ch_evt;
  assign capture_value        = s_q.capval;
  assign channel_input        = s_q.ch_in;
  assign update_inhibit       = s_q.inhibit;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_cap_flag;
    is_input && capture_event |=> channel_event_flag;
  endproperty
  a_cap_flag: assert property (p_cap_flag) // R1
    else $error("capture did not set channel flag");

  property p_cmp_flag;
    is_output && compare_event |=> channel_event_flag && channel_event;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) // R2
    else $error("compare did not set channel flag");

  property p_ch_hold;
    $fell(channel_event_flag) |->
      $past(wr_flags && byteenable[0] && !writedata[BIT_CH_FLAG] && !ch_set);
  endproperty
  a_ch_hold: assert property (p_ch_hold) // R3
    else $error("channel flag cleared without software");

  property p_upd_flag;
    hw_update_event |=> update_event_flag && update_event;
  endproperty
  a_upd_flag: assert property (p_upd_flag) // R4
    else $error("update event did not set flag");

  property p_one_keeps;
    update_event_flag && wr_flags && writedata[BIT_UPD_FLAG] |=> update_event_flag;
  endproperty
  a_one_keeps: assert property (p_one_keeps) // R5
    else $error("writing one changed update flag");

  property p_ch_gen_pulse;
    sw_ch ##1 !ch_set |-> channel_event ##1 !channel_event;
  endproperty
  a_ch_gen_pulse: assert property (p_ch_gen_pulse) // R6
    else $error("channel generate not self clearing");

  property p_sw_ch_flag;
    sw_ch |=> channel_event_flag && channel_event;
  endproperty
  a_sw_ch_flag: assert property (p_sw_ch_flag) // R7
    else $error("software channel event lost");

  property p_sw_capture;
    sw_ch && is_input |=> capture_value == $past(counter_value);
  endproperty
  a_sw_capture: assert property (p_sw_capture) // R8
    else $error("software capture value wrong");

  property p_overrun;
    cap_hit && channel_event_flag |=> capture_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) // R9
    else $error("overrun flag not set");

  property p_upd_clear;
    sw_upd ##1 !sw_upd |-> counter_clear && prescaler_clear ##1 !counter_clear;
  endproperty
  a_upd_clear: assert property (p_upd_clear) // R11
    else $error("update generate did not clear counter");

  property p_inhibit;
    sw_upd && update_inhibit && !hw_update_event |=> counter_clear && !update_event;
  endproperty
  a_inhibit: assert property (p_inhibit) // R14
    else $error("inhibited update produced event");

  property p_reserved_dir;
    !is_input && !is_output && !sw_ch |=> !channel_event;
  endproperty
  a_reserved_dir: assert property (p_reserved_dir) // R15
    else $error("reserved direction produced event");

  property p_upd_gen;
    sw_upd && !update_inhibit |=> update_event && update_event_flag;
  endproperty
  a_upd_gen: assert property (p_upd_gen) // R10
    else $error("update generate produced no update event");

  property p_upd_quiet;
    !hw_update_event && !sw_upd |=> !update_event;
  endproperty
  a_upd_quiet: assert property (p_upd_quiet) // R10
    else $error("update pulse without request");

  property p_psc_clear;
    sw_upd |=> prescaler_clear && counter_clear;
  endproperty
  a_psc_clear: assert property (p_psc_clear) // R12
    else $error("prescaler not cleared with counter");

  property p_psc_quiet;
    !sw_upd |=> !prescaler_clear && !counter_clear;
  endproperty
  a_psc_quiet: assert property (p_psc_quiet) // R12
    else $error("clear pulse without update request");

  property p_word_only;
    wr_stb && (address == OFS_CHMODE) && (byteenable != BE_WORD) |=> $stable(s_q.chmode);
  endproperty
  a_word_only: assert property (p_word_only) // R13
    else $error("partial write changed channel mode");

  property p_word_write;
    wr_stb && (address == OFS_CHMODE) && (byteenable == BE_WORD) |=>
      s_q.chmode == $past(writedata[CHMODE_W-1:0]);
  endproperty
  a_word_write: assert property (p_word_write) // R13
    else $error("word write to channel mode lost");

  property p_ovr_hold;
    $fell(capture_overrun_flag) |->
      $past(wr_flags && byteenable[1] && !writedata[BIT_OVR_FLAG] && !(cap_hit && s_q.ch_flag));
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) // R9
    else $error("overrun flag cleared without software");

  property p_upd_hold;
    $fell(update_event_flag) |->
      $past(wr_flags && byteenable[0] && !writedata[BIT_UPD_FLAG] && !upd_set);
  endproperty
  a_upd_hold: assert property (p_upd_hold) // R5
    else $error("update flag cleared without software");

  property p_ch_rise;
    $rose(channel_event_flag) |-> $past(capture_event || compare_event || sw_ch);
  endproperty
  a_ch_rise: assert property (p_ch_rise) // R3
    else $error("channel flag set without an event");

  property p_zero_clears;
    wr_flags && byteenable[0] && !writedata[BIT_CH_FLAG] && !ch_set |=> !channel_event_flag;
  endproperty
  a_zero_clears: assert property (p_zero_clears) // R5
    else $error("writing zero did not clear channel flag");

  property p_sw_no_cap;
    sw_ch && !is_input && !(is_input && capture_event) |=> $stable(capture_value);
  endproperty
  a_sw_no_cap: assert property (p_sw_no_cap) // R8
    else $error("software event captured outside input mode");

  property p_inhibit_flag;
    sw_upd && update_inhibit && !hw_update_event && !update_event_flag |=> !update_event_flag;
  endproperty
  a_inhibit_flag: assert property (p_inhibit_flag) // R14
    else $error("inhibited update set the flag");

  property p_cap_value;
    cap_hit |=> capture_value == $past(counter_value);
  endproperty
  a_cap_value: assert property (p_cap_value) // R1
    else $error("capture did not load counter value");

  property p_cmp_no_cap;
    is_output && compare_event && !sw_ch |=> $stable(capture_value);
  endproperty
  a_cmp_no_cap: assert property (p_cmp_no_cap) // R2
    else $error("compare changed captured value");

  property p_ch_quiet;
    !capture_event && !compare_event && !sw_ch |=> !channel_event;
  endproperty
  a_ch_quiet: assert property (p_ch_quiet) // R6
    else $error("channel pulse without event");

  c_overrun: cover property (cap_hit && channel_event_flag ##1 capture_overrun_flag);
  c_sw_upd: cover property (sw_upd ##1 counter_clear);
  c_set_wins: cover property (ch_set && wr_flags ##1 channel_event_flag);
  c_reserved_gen: cover property (sw_ch && !is_input && !is_output ##1 channel_event_flag);
  c_inhibit: cover property (sw_upd && update_inhibit ##1 counter_clear && !update_event);
endmodule // tef_timer_flags
